// File: hdl/sild_pkg.sv
// Shared constants for the serial-in latched driver and its host controller.
// Assumes both ends run on one 25 MHz clock and share this package.
package sild_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Structure
  //////////////////////////////////////////////////////////////////////////////

  // Number of shift stages, latches and output drivers.
  localparam int STAGES    = 32;
  // Width of the stage index counter in the host.
  localparam int BIT_CNT_W = 6;
  // Depth of the host word FIFO.
  localparam int FIFO_DEPTH = 8;

  // Positions of the link pins inside the device's synchroniser vector.
  localparam int PIN_DATA  = 0;
  localparam int PIN_CLK   = 1;
  localparam int PIN_STRB  = 2;
  localparam int PIN_OE    = 3;
  localparam int PIN_COUNT = 4;

  // Reset values.
  localparam logic [STAGES-1:0]    STAGE_RST = 32'h0000_0000;
  localparam logic [PIN_COUNT-1:0] PIN_RST   = 4'h0;

  //////////////////////////////////////////////////////////////////////////////
  // Timing
  //////////////////////////////////////////////////////////////////////////////

  // Clock period in ns (25 MHz).
  localparam int CLK_NS        = 40;
  // Least times in ns, as printed.
  localparam int DATA_SETUP_NS = 75;
  localparam int DATA_HOLD_NS  = 75;
  localparam int CLK_PULSE_NS  = 150;
  localparam int STRB_GAP_NS   = 300;
  localparam int STRB_PULSE_NS = 100;

  // Least times rounded up to whole clock cycles.
  localparam int SETUP_CYC = (DATA_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC  = (DATA_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CLK_CYC   = (CLK_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC   = (STRB_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STRB_CYC  = (STRB_PULSE_NS + CLK_NS - 1) / CLK_NS;

  // Width of the host's phase timer.
  localparam int TIMER_W = 4;

  // Host sequencer states, Gray coded from IDLE through STRB in that order.
  typedef enum logic [2:0] {
    SILD_IDLE  = 3'h0,
    SILD_SETUP = 3'h1,
    SILD_HIGH  = 3'h3,
    SILD_LOW   = 3'h2,
    SILD_GAP   = 3'h6,
    SILD_STRB  = 3'h7
  } sild_state_t;

endpackage

// File: hdl/sild_if.sv
// Link between the host controller and the serial-in latched driver.
// Assumes the testbench resolves the open-collector driver wires from drv_oe.
`timescale 1ns/10ps

interface sild_if;

  // Serial data from the host.
  logic                         ser_data;
  // Shift clock from the host; data is taken on its rising edge.
  logic                         shift_clk;
  // Latch strobe; latches are transparent while it is high.
  logic                         strobe;
  // Output enable; drivers are off while it is low.
  logic                         out_en;
  // Cascade output from the last shift stage.
  logic                         cascade_out;
  // Open-collector driver level, always low when driven.
  logic [sild_pkg::STAGES-1:0]  drv_out;
  // High while a driver sinks its output.
  logic [sild_pkg::STAGES-1:0]  drv_oe;

  // Driver end.
  modport dev (
    input  ser_data,
    input  shift_clk,
    input  strobe,
    input  out_en,
    output cascade_out,
    output drv_out,
    output drv_oe
  );

  // Controller end.
  modport host (
    output ser_data,
    output shift_clk,
    output strobe,
    output out_en,
    input  cascade_out,
    input  drv_out,
    input  drv_oe
  );

endinterface

// File: hdl/sild_driver.sv
// Driver end: 32-stage shift register, transparent latches, gated drivers.
// Assumes link pins arrive asynchronously and are resynchronised here.
//
// Functional notes
// - 32 shift stages, latches and drivers.
// - Rising shift clock loads serial data.
// - Each rising edge shifts toward cascade.
// - Latches follow stages while strobe high.
// - High strobe keeps latches copying shifts.
// - Host keeps enable low when bypassing latches during a frame.
// - Enable low turns drivers off, keeps state.
// - Enable high drives from latch state.
// - Host holds shift clock high 150 ns.
// - Host keeps data valid 150 ns.
// - Host waits 300 ns before strobing.
// - Host strobe pulse lasts 100 ns.
`timescale 1ns/10ps

module sild_driver (
  input  wire logic                        core_clk,
  input  wire logic                        reset_n,
  sild_if.dev                              link,
  output logic     [sild_pkg::STAGES-1:0]  latch_state,
  output logic     [sild_pkg::STAGES-1:0]  stage_state
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  //////////////////////////////////////////////////////////////////////////////

  // First flop of each pin; read only by the second stage.
  logic [sild_pkg::PIN_COUNT-1:0] pin_meta;
  // Second and third stages; a change counts once they agree.
  logic [sild_pkg::PIN_COUNT-1:0] pin_s2;
  logic [sild_pkg::PIN_COUNT-1:0] pin_s3;
  // Accepted, filtered pin levels.
  logic [sild_pkg::PIN_COUNT-1:0] pin_level;
  // Vector of raw pins in synchroniser order.
  logic [sild_pkg::PIN_COUNT-1:0] pin_raw;

  // Gather the pins into one vector so one chain serves them all.
  always_comb begin
    pin_raw                      = sild_pkg::PIN_RST;
    pin_raw[sild_pkg::PIN_DATA]  = link.ser_data;
    pin_raw[sild_pkg::PIN_CLK]   = link.shift_clk;
    pin_raw[sild_pkg::PIN_STRB]  = link.strobe;
    pin_raw[sild_pkg::PIN_OE]    = link.out_en;
  end

  // Three-flop chain; the third stage guards against a late-settling second.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta <= sild_pkg::PIN_RST;
      pin_s2   <= sild_pkg::PIN_RST;
      pin_s3   <= sild_pkg::PIN_RST;
    end else begin
      pin_meta <= pin_raw;
      pin_s2   <= pin_meta;
      pin_s3   <= pin_s2;
    end
  end

  // Accept a pin's new level only when the last two stages agree.
  // This costs one cycle of latency but filters a single-cycle glitch.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_level <= sild_pkg::PIN_RST;
    end else begin
      for (int i = 0; i < sild_pkg::PIN_COUNT; i++) begin
        if (pin_s2[i] == pin_s3[i]) begin
          pin_level[i] <= pin_s3[i];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shift clock edge
  //////////////////////////////////////////////////////////////////////////////

  // One-cycle pulse on each accepted low-to-high change of the shift clock.
  logic shift_edge;
  // Data level paired with the edge.
  logic shift_bit;

  // The edge is seen when the agreed new level is high and the old one low.
  always_comb begin
    shift_edge = pin_s2[sild_pkg::PIN_CLK] && pin_s3[sild_pkg::PIN_CLK] &&
                 !pin_level[sild_pkg::PIN_CLK];
    // The data has settled long before the clock pin, so its filtered copy
    // is safe to use even though it runs through the same chain.
    shift_bit  = pin_level[sild_pkg::PIN_DATA];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shift register, latches and drivers
  //////////////////////////////////////////////////////////////////////////////

  // Shift register stages; index 0 is the first stage.
  logic [sild_pkg::STAGES-1:0] stage;
  // Latches, one per stage.
  logic [sild_pkg::STAGES-1:0] latch;
  // Registered driver enables.
  logic [sild_pkg::STAGES-1:0] drive;
  // Registered cascade output.
  logic                        cascade;

  // Filtered strobe and enable levels.
  logic strobe_on;
  logic enable_on;

  // Name the two control levels for readability.
  always_comb begin
    strobe_on = pin_level[sild_pkg::PIN_STRB];
    enable_on = pin_level[sild_pkg::PIN_OE];
  end

  // One slice per stage: shift, latch and driver.
  for (genvar g = 0; g < sild_pkg::STAGES; g++) begin : g_stage
    // Source of this stage on a shift: the serial input or the stage before.
    logic stage_in;

    // The first stage takes the serial input; the rest take their neighbour.
    if (g == 0) begin : g_first
      always_comb begin
        stage_in = shift_bit;
      end
    end else begin : g_rest
      always_comb begin
        stage_in = stage[g-1];
      end
    end

    // Shift only on an accepted rising shift clock; enable has no effect here.
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        stage[g] <= sild_pkg::STAGE_RST[g];
      end else if (shift_edge) begin
        stage[g] <= stage_in;
      end
    end

    // Latch copies its stage while the strobe is high and holds when low.
    // Modelled as a clocked copy, so it trails the stage by one cycle; this
    // avoids a real transparent latch in the fabric.
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        latch[g] <= sild_pkg::STAGE_RST[g];
      end else if (strobe_on) begin
        latch[g] <= stage[g];
      end
    end

    // Driver sinks when enabled and its latch holds a one; off otherwise.
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        drive[g] <= 1'b0;
      end else begin
        drive[g] <= enable_on && latch[g];
      end
    end
  end

  // Cascade output follows the final stage so another device can chain on.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cascade <= 1'b0;
    end else begin
      cascade <= stage[sild_pkg::STAGES-1];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  //////////////////////////////////////////////////////////////////////////////

  // Open-collector pins only ever pull low; drv_oe says when they sink.
  assign link.drv_out     = sild_pkg::STAGE_RST;
  assign link.drv_oe      = drive;
  assign link.cascade_out = cascade;

  // Internal state exposed on the user side for observation.
  assign latch_state = latch;
  assign stage_state = stage;

endmodule

// File: hdl/sild_host.sv
// Host end: word FIFO and a sequencer that shifts, strobes and enables.
// Assumes the driver end samples the pins with its own synchronisers.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Word FIFO
////////////////////////////////////////////////////////////////////////////////

module sild_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int PW = $clog2(DEPTH);

  // Storage array.
  logic [WIDTH-1:0] mem [DEPTH];
  // Read and write pointers and fill count.
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;

  // Full and empty follow the count exactly, so ready stalls the writer.
  assign in_ready  = (count != PW'(0) + (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Write port.
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and count; wrap is explicit because DEPTH need not be a power.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + PW'(1);
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule

////////////////////////////////////////////////////////////////////////////////
// Sequencer
////////////////////////////////////////////////////////////////////////////////

module sild_host (
  input  wire logic                        core_clk,
  input  wire logic                        reset_n,
  input  wire logic [sild_pkg::STAGES-1:0] word_data,
  input  wire logic                        word_valid,
  output logic                             word_ready,
  input  wire logic                        enable_outputs,
  input  wire logic                        bypass_latch,
  output logic                             busy,
  sild_if.host                             link
);

  // FIFO read side.
  logic [sild_pkg::STAGES-1:0] fifo_data;
  logic                        fifo_valid;
  logic                        fifo_take;

  sild_fifo #(
    .WIDTH (sild_pkg::STAGES),
    .DEPTH (sild_pkg::FIFO_DEPTH)
  ) sild_fifo_i (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .in_data   (word_data),
    .in_valid  (word_valid),
    .in_ready  (word_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_take)
  );

  sild_pkg::sild_state_t                state;
  logic [sild_pkg::STAGES-1:0]          shreg;     // Word being sent, MSB first.
  logic [sild_pkg::BIT_CNT_W-1:0]       bits_left; // Bits still to send.
  logic [sild_pkg::TIMER_W-1:0]         timer;     // Cycles left in a phase.
  logic                                 pin_data;
  logic                                 pin_clk;
  logic                                 pin_strb;
  logic                                 pin_oe;

  // Take a word only when idle; the FIFO then backs up toward the user.
  assign fifo_take = (state == sild_pkg::SILD_IDLE) && fifo_valid;
  assign busy      = (state != sild_pkg::SILD_IDLE);

  // Sequencer: setup, clock high, clock low per bit, then gap and strobe.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state     <= sild_pkg::SILD_IDLE;
      shreg     <= sild_pkg::STAGE_RST;
      bits_left <= '0;
      timer     <= '0;
    end else begin
      case (state)
        sild_pkg::SILD_IDLE: begin
          if (fifo_valid) begin
            shreg     <= fifo_data;
            bits_left <= sild_pkg::BIT_CNT_W'(sild_pkg::STAGES);
            timer     <= sild_pkg::TIMER_W'(sild_pkg::SETUP_CYC);
            state     <= sild_pkg::SILD_SETUP;
          end
        end
        sild_pkg::SILD_SETUP: begin
          timer <= timer - sild_pkg::TIMER_W'(1);
          if (timer == sild_pkg::TIMER_W'(1)) begin
            timer <= sild_pkg::TIMER_W'(sild_pkg::CLK_CYC);
            state <= sild_pkg::SILD_HIGH;
          end
        end
        sild_pkg::SILD_HIGH: begin
          // Clock stays high and data stays put for the whole pulse.
          timer <= timer - sild_pkg::TIMER_W'(1);
          if (timer == sild_pkg::TIMER_W'(1)) begin
            timer <= sild_pkg::TIMER_W'(sild_pkg::CLK_CYC);
            state <= sild_pkg::SILD_LOW;
          end
        end
        sild_pkg::SILD_LOW: begin
          // Low phase covers the hold time and the least low width.
          timer <= timer - sild_pkg::TIMER_W'(1);
          if (timer == sild_pkg::TIMER_W'(1)) begin
            if (bits_left == sild_pkg::BIT_CNT_W'(1)) begin
              timer <= sild_pkg::TIMER_W'(sild_pkg::GAP_CYC);
              state <= sild_pkg::SILD_GAP;
            end else begin
              shreg     <= {shreg[sild_pkg::STAGES-2:0], 1'b0};
              bits_left <= bits_left - sild_pkg::BIT_CNT_W'(1);
              timer     <= sild_pkg::TIMER_W'(sild_pkg::SETUP_CYC);
              state     <= sild_pkg::SILD_SETUP;
            end
          end
        end
        sild_pkg::SILD_GAP: begin
          timer <= timer - sild_pkg::TIMER_W'(1);
          if (timer == sild_pkg::TIMER_W'(1)) begin
            timer <= sild_pkg::TIMER_W'(sild_pkg::STRB_CYC);
            state <= sild_pkg::SILD_STRB;
          end
        end
        sild_pkg::SILD_STRB: begin
          timer <= timer - sild_pkg::TIMER_W'(1);
          if (timer == sild_pkg::TIMER_W'(1)) begin
            state <= sild_pkg::SILD_IDLE;
          end
        end
        default: begin
          state <= sild_pkg::SILD_IDLE;
        end
      endcase
    end
  end

  // Registered pins; bypass holds strobe high and forces enable low in a frame.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_data <= 1'b0;
      pin_clk  <= 1'b0;
      pin_strb <= 1'b0;
      pin_oe   <= 1'b0;
    end else begin
      pin_data <= shreg[sild_pkg::STAGES-1];
      pin_clk  <= (state == sild_pkg::SILD_HIGH);
      pin_strb <= bypass_latch || (state == sild_pkg::SILD_STRB);
      pin_oe   <= enable_outputs && !(bypass_latch && busy);
    end
  end

  assign link.ser_data  = pin_data;
  assign link.shift_clk = pin_clk;
  assign link.strobe    = pin_strb;
  assign link.out_en    = pin_oe;

endmodule

// File: tb/sild_assertions.sv
// Checker for the link between host and driver ends.
// Assumes it sees the interface signals and the shared clock and reset.
`timescale 1ns/10ps

module sild_assertions (
  input wire logic                        core_clk,
  input wire logic                        reset_n,
  input wire logic                        ser_data,
  input wire logic                        shift_clk,
  input wire logic                        strobe,
  input wire logic                        out_en,
  input wire logic                        cascade_out,
  input wire logic [sild_pkg::STAGES-1:0] drv_out,
  input wire logic [sild_pkg::STAGES-1:0] drv_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////
  // Cycles since the shift clock was last high, saturating so it never wraps.
  logic [3:0] gap_cnt;   // Starts full, since no clock came before reset.

  // One counter per concern; cleared whenever the shift clock is high.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_cnt <= 4'hf;
    end else if (shift_clk) begin
      gap_cnt <= 4'h0;
    end else if (gap_cnt != 4'hf) begin
      gap_cnt <= gap_cnt + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_clk_high_len: assert property ($rose(shift_clk) |-> shift_clk [*4])
    else $error("shift clock pulse shorter than four cycles");
  a_data_held: assert property ($rose(shift_clk) |-> ##1 $stable(ser_data) [*3])
    else $error("serial data moved during the clock pulse");
  a_strobe_len: assert property ($rose(strobe) |-> strobe [*3])
    else $error("strobe pulse shorter than three cycles");
  a_strobe_gap: assert property ($rose(strobe) |-> gap_cnt >= 4'(sild_pkg::GAP_CYC))
    else $error("strobe raised too soon after the shift clock");
  a_bypass_dark: assert property (shift_clk && strobe |-> !out_en)
    else $error("outputs enabled while shifting through open latches");
  a_wire_low: assert property (drv_out == 32'h0000_0000)
    else $error("driver wire driven high");
  a_oe_off: assert property (!out_en [*8] |-> drv_oe == 32'h0000_0000)
    else $error("driver sinking while enable is low");
  a_cascade_step: assert property ($changed(cascade_out) |->
      $past(shift_clk, 2) || $past(shift_clk, 3) || $past(shift_clk, 4))
    else $error("cascade output moved without a shift clock");
  a_latch_hold: assert property ((!strobe && out_en) [*8] |=> $stable(drv_oe))
    else $error("drivers changed while the strobe was low");

  // Main scenarios: a shift clock edge, a strobe, and outputs gated off.
  c_shift: cover property ($rose(shift_clk));
  c_strobe: cover property ($fell(strobe));
  c_dark: cover property ($fell(out_en));
endmodule

// File: tb/sild_tb.sv
// Self-checking bench: host end drives the driver end over the link.
// Assumes the design package, interface and both ends are compiled first.
`timescale 1ns/10ps

module sild_tb;
  logic        core_clk = 1'b0;                 // 25 MHz clock.
  logic        reset_n = 1'b0;                  // Held low at start.
  logic [31:0] word_data = 32'h0000_0000;       // Word offered to the host.
  logic        word_valid = 1'b0;               // Offer strobe.
  logic        enable_outputs = 1'b1;           // User wants drivers on.
  logic        bypass_latch = 1'b0;             // Latches normally used.
  logic        word_ready;                      // FIFO has room.
  logic        busy;                            // Host frame in progress.
  logic [31:0] latch_state;                     // Latch contents.
  logic [31:0] stage_state;                     // Shift stage contents.
  logic [31:0] out_pins;                        // Resolved output wires.
  int          err_count = 0;                   // Mismatches seen.
  int          num_checks = 0;                  // Comparisons made.
  logic [31:0] words [9] = '{32'ha5c3_0f96, 32'h0000_0000, 32'hffff_ffff,
    32'h8000_0001, 32'h1234_5678, 32'h7fff_fffe, 32'h0f0f_f0f0, 32'hdead_0001,
    32'h5555_aaaa};                             // Edge and mixed patterns.

  sild_if link ();

  // Open-collector wires with pull-ups: low only where a driver sinks.
  assign out_pins = (link.drv_oe & link.drv_out) | ~link.drv_oe;

  sild_host   sild_host_i (.core_clk(core_clk), .reset_n(reset_n),
    .word_data(word_data), .word_valid(word_valid), .word_ready(word_ready),
    .enable_outputs(enable_outputs), .bypass_latch(bypass_latch), .busy(busy),
    .link(link));
  sild_driver sild_driver_i (.core_clk(core_clk), .reset_n(reset_n), .link(link),
    .latch_state(latch_state), .stage_state(stage_state));
  sild_assertions sild_assertions_i (.core_clk(core_clk), .reset_n(reset_n),
    .ser_data(link.ser_data), .shift_clk(link.shift_clk), .strobe(link.strobe),
    .out_en(link.out_en), .cascade_out(link.cascade_out),
    .drv_out(link.drv_out), .drv_oe(link.drv_oe));

  ////////////////////////////////////////////////////////////////////////////
  // Clock: half period 20 ns.
  initial begin
    forever #20 core_clk = ~core_clk;
  end

  // Compare, count, and report a mismatch at once.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Offer one word and hold it until the FIFO takes it; valid stays up.
  task automatic push(input logic [31:0] w);
    int n;
    n = 0;
    word_data <= w;
    word_valid <= 1'b1;
    @(negedge core_clk);
    while (word_ready !== 1'b1 && n < 1000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 1000) err_count++;
    @(posedge core_clk);
  endtask

  // Wait for the next frame to end; bounded so a hang is counted, not waited.
  task automatic wait_frame();
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 1000) begin
      @(negedge core_clk);
      n++;
    end
    // A frame that never starts is a hang too, not a quiet pass.
    if (n >= 1000) err_count++;
    while (busy !== 1'b0 && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 2000) err_count++;
  endtask

  // After a frame: stages now, latches and drivers once the strobe lands.
  task automatic frame_done(input logic [31:0] w, input logic en);
    wait_frame();
    check(stage_state, w);
    check({31'h0, link.cascade_out}, {31'h0, w[31]});
    repeat (7) @(negedge core_clk);
    check(latch_state, w);
    check(link.drv_oe, en ? w : 32'h0000_0000);
    check(out_pins, en ? ~w : 32'hffff_ffff);
  endtask

  // Summary line, verdict, end of run.
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: ten frames take about 3500 cycles, so 20000 means a hang.
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    test_done();
  end

  // Main sequence.
  initial begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    @(negedge core_clk);
    check(link.drv_oe, 32'h0000_0000);
    check({31'h0, word_ready}, 32'h0000_0001);
    @(posedge core_clk);
    // Back to back until the FIFO refuses; one word is already in flight.
    for (int i = 0; i < 9; i++) begin
      push(words[i]);
    end
    word_valid <= 1'b0;
    @(negedge core_clk);
    check({31'h0, word_ready}, 32'h0000_0000);
    for (int i = 0; i < 9; i++) begin
      frame_done(words[i], 1'b1);
    end
    // Gate the drivers off: state must survive, then come back unchanged.
    @(posedge core_clk);
    enable_outputs <= 1'b0;
    repeat (10) @(negedge core_clk);
    check(link.drv_oe, 32'h0000_0000);
    check(latch_state, words[8]);
    @(posedge core_clk);
    enable_outputs <= 1'b1;
    repeat (10) @(negedge core_clk);
    check(link.drv_oe, words[8]);
    // Latches bypassed: they track the stages and outputs stay dark meanwhile.
    @(posedge core_clk);
    bypass_latch <= 1'b1;
    repeat (10) @(posedge core_clk);
    push(32'hc001_d00d);
    word_valid <= 1'b0;
    frame_done(32'hc001_d00d, 1'b1);
    test_done();
  end
endmodule
